/* File: bism_defines.vh */
// constants for the bridge interrupt status and mapping block
// assumes a 32-bit APB slave with byte addresses on paddr[7:0]
`ifndef BISM_DEFINES_VH
`define BISM_DEFINES_VH

// register byte offsets
`define BISM_OFS_NORM_STAT  8'h00
`define BISM_OFS_EXC_STAT   8'h04
`define BISM_OFS_NORM_EN    8'h08
`define BISM_OFS_EXC_EN     8'h0C
`define BISM_OFS_DOORBELL   8'h10
`define BISM_OFS_PIN_DIR    8'h14
`define BISM_OFS_MAP_BASE   8'h40
`define BISM_OFS_MAP_LAST   8'h5C
`define BISM_OFS_MBOX_BASE  8'h60
`define BISM_OFS_MBOX_LAST  8'h7C

// normal_event_status field positions
`define BISM_NS_MBOX_LO     0
`define BISM_NS_DB_LO       8
`define BISM_NS_HW_LO       16
`define BISM_NS_DMA_LO      24
`define BISM_NS_INBOUND     28
`define BISM_NS_OUTBOUND    29
`define BISM_NS_SUMMARY     31
`define BISM_NS_SRC_MASK    32'h3FFFFFFF

// exception_event_status field positions, summary in bit 31
`define BISM_ES_CPU_BUSERR_LO  0
`define BISM_ES_CPU_DPAR_LO    3
`define BISM_ES_CPU_RETRY_LO   6
`define BISM_ES_CPU_APAR       9
`define BISM_ES_P1_BUSERR_LO   10
`define BISM_ES_P1_RETRY_LO    13
`define BISM_ES_P1_APAR        16
`define BISM_ES_P2_BUSERR_LO   17
`define BISM_ES_P2_RETRY_LO    20
`define BISM_ES_P2_APAR        23
`define BISM_ES_SUMMARY        31
`define BISM_ES_SRC_MASK       32'h00FFFFFF

// reset values
`define BISM_RST_STAT    32'h00000000
`define BISM_RST_EN      32'h00000000
`define BISM_RST_DIR     8'h00
`define BISM_RST_MAP     3'h0
`define BISM_RST_MBOX    32'h00000000

`endif

/* File: bism_irq_ctrl.v */
// interrupt status, enable, mapping, direction and mailbox block
// assumes APB3 master, zero-wait answer, pins resolved outside
//
// What this block does
// - eight interrupt pins: port one line, port two line, six general.
// - one direction bit per pin selects input-only or output-only.
// - an active source sets its bit in one of two status registers.
// - status bits read normally; all but outbound and summary bits clear only by writing one.
// - a set status bit reaches a pin only when its enable is set.
// - mapping registers steer each source to one chosen pin.
// - eight 32-bit read/write mailbox registers for messages.
// - all status bits read clear after reset.
// - normal register holds queue, dma, pin, doorbell, mailbox events.
// - normal register summary bit shows any exception bit set.
// - outbound queue bit mirrors pending addresses, writes ignored.
// - inbound queue bit set while addresses pending, write one clears.
// - per dma channel bit set on channel interrupt, write one clears.
// - per pin bit set on pending input interrupt, write one clears.
// - doorbell bit set by doorbell write, write one clears.
// - mailbox bit set by mailbox write, write one clears.
// - bus and address parity errors on all ports, data parity on the cpu port only, raise exceptions.
// - exception flags kept per reporting port and path direction.
// - cpu port: bus error, data parity, retry per path, one address parity.
// - each pci port: bus error and retry per path, one address parity.
// - exception register summary bit shows any normal bit set.
// - all enable bits clear at reset.
`timescale 1ns/100ps
`include "bism_defines.vh"

module bism_irq_ctrl (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // event sources, high while active
  input  wire        outboundPending,
  input  wire        inboundPending,
  input  wire [3:0]  dmaChannelEvent,
  input  wire [2:0]  cpuBusErr,
  input  wire [2:0]  cpuDataParityErr,
  input  wire [2:0]  cpuRetryOverflow,
  input  wire        cpuAddrParityErr,
  input  wire [2:0]  portOneBusErr,
  input  wire [2:0]  portOneRetryOverflow,
  input  wire        portOneAddrParityErr,
  input  wire [2:0]  portTwoBusErr,
  input  wire [2:0]  portTwoRetryOverflow,
  input  wire        portTwoAddrParityErr,
  // interrupt pins, active low, bit 0 port one, bit 1 port two
  input  wire [7:0]  irqPinInN,
  output wire [7:0]  irqPinOut,
  output reg  [7:0]  irqPinOe
);

  // register state
  reg  [31:0] normStat;
  reg  [31:0] excStat;
  reg  [31:0] normEn;
  reg  [31:0] excEn;
  reg  [7:0]  pinDir;
  wire [255:0] mboxRd;
  wire [255:0] mapRd;
  wire [191:0] mapFlat;

  // apb phase tracker; a write lands only after a seen setup cycle,
  // so a master that raises penable without setup cannot corrupt state
  localparam [2:0] PH_IDLE   = 3'b001;
  localparam [2:0] PH_SETUP  = 3'b010;
  localparam [2:0] PH_ACCESS = 3'b100;

  reg [2:0] phase;
  reg [2:0] next_phase;

  always @* begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (psel && !penable)
          next_phase = PH_SETUP;
      end
      PH_SETUP: begin
        if (psel && penable)
          next_phase = PH_ACCESS;
        else if (!psel)
          next_phase = PH_IDLE;
      end
      PH_ACCESS: begin
        if (psel && !penable)
          next_phase = PH_SETUP;
        else
          next_phase = PH_IDLE;
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      phase <= PH_IDLE;
    else
      phase <= next_phase;
  end

  // bus decode
  wire        setupPh = psel & ~penable;
  wire        wrAcc   = psel & penable & pwrite & (phase == PH_SETUP);
  wire [7:0]  addrW   = {paddr[7:2], 2'b00};
  wire        hitMap  = (addrW >= `BISM_OFS_MAP_BASE) && (addrW <= `BISM_OFS_MAP_LAST);
  wire        hitMbox = (addrW >= `BISM_OFS_MBOX_BASE) && (addrW <= `BISM_OFS_MBOX_LAST);
  wire [2:0]  wordIdx = addrW[4:2];

  wire wrNormStat = wrAcc && (addrW == `BISM_OFS_NORM_STAT);
  wire wrExcStat  = wrAcc && (addrW == `BISM_OFS_EXC_STAT);
  wire wrNormEn   = wrAcc && (addrW == `BISM_OFS_NORM_EN);
  wire wrExcEn    = wrAcc && (addrW == `BISM_OFS_EXC_EN);
  wire wrDoorbell = wrAcc && (addrW == `BISM_OFS_DOORBELL);
  wire wrPinDir   = wrAcc && (addrW == `BISM_OFS_PIN_DIR);

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;

  // open-drain style pins, only the enable moves
  assign irqPinOut = 8'h00;

  // mailbox write strobes, one per mailbox
  wire [7:0] mboxWr;
  genvar w;
  generate
    for (w = 0; w < 8; w = w + 1) begin : gMboxWr
      assign mboxWr[w] = wrAcc && hitMbox && (wordIdx == w);
    end
  endgenerate

  // pin input events; an output pin never reports,
  // its own drive would otherwise loop back as an event
  wire [7:0] pinEvent;
  genvar h;
  generate
    for (h = 0; h < 8; h = h + 1) begin : gPinIn
      assign pinEvent[h] = !irqPinInN[h] && !pinDir[h];
    end
  endgenerate

  // normal source set terms
  wire [7:0] dbSet    = wrDoorbell ? pwdata[7:0] : 8'h00;

  reg [31:0] normSet;
  always @* begin
    normSet = 32'h00000000;
    normSet[`BISM_NS_MBOX_LO +: 8] = mboxWr;
    normSet[`BISM_NS_DB_LO +: 8]   = dbSet;
    normSet[`BISM_NS_HW_LO +: 8]   = pinEvent;
    normSet[`BISM_NS_DMA_LO +: 4]  = dmaChannelEvent;
    normSet[`BISM_NS_INBOUND]      = inboundPending;
  end

  // exception set terms, grouped by reporting port, then error kind, then path
  reg [31:0] excSet;
  always @* begin
    excSet = 32'h00000000;
    excSet[`BISM_ES_CPU_BUSERR_LO +: 3] = cpuBusErr;
    excSet[`BISM_ES_CPU_DPAR_LO +: 3]   = cpuDataParityErr;
    excSet[`BISM_ES_CPU_RETRY_LO +: 3]  = cpuRetryOverflow;
    excSet[`BISM_ES_CPU_APAR]           = cpuAddrParityErr;
    excSet[`BISM_ES_P1_BUSERR_LO +: 3]  = portOneBusErr;
    excSet[`BISM_ES_P1_RETRY_LO +: 3]   = portOneRetryOverflow;
    excSet[`BISM_ES_P1_APAR]            = portOneAddrParityErr;
    excSet[`BISM_ES_P2_BUSERR_LO +: 3]  = portTwoBusErr;
    excSet[`BISM_ES_P2_RETRY_LO +: 3]   = portTwoRetryOverflow;
    excSet[`BISM_ES_P2_APAR]            = portTwoAddrParityErr;
  end

  // write-one-to-clear masks; outbound bit is never cleared by software
  wire [31:0] normClr = wrNormStat ? (pwdata & `BISM_NS_SRC_MASK) : 32'h00000000;
  wire [31:0] excClr  = wrExcStat ? (pwdata & `BISM_ES_SRC_MASK) : 32'h00000000;

  // summaries come from the latched bits only, so no loop through each other
  wire normAny = |(normStat & `BISM_NS_SRC_MASK);
  wire excAny  = |(excStat & `BISM_ES_SRC_MASK);

  reg [31:0] next_normStat;
  reg [31:0] next_excStat;
  always @* begin
    // set beats a clear in the same cycle so no event is lost
    next_normStat = ((normStat & ~normClr) | normSet) & `BISM_NS_SRC_MASK;
    next_normStat[`BISM_NS_OUTBOUND] = outboundPending;
    next_normStat[`BISM_NS_SUMMARY]  = excAny;
    next_excStat = ((excStat & ~excClr) | excSet) & `BISM_ES_SRC_MASK;
    next_excStat[`BISM_ES_SUMMARY] = normAny;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      normStat <= `BISM_RST_STAT;
      excStat  <= `BISM_RST_STAT;
    end else begin
      normStat <= next_normStat;
      excStat  <= next_excStat;
    end
  end

  // enables and pin direction
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      normEn <= `BISM_RST_EN;
      excEn  <= `BISM_RST_EN;
      pinDir <= `BISM_RST_DIR;
    end else begin
      if (wrNormEn) begin
        normEn <= pwdata & `BISM_NS_SRC_MASK;
      end
      if (wrExcEn) begin
        excEn <= pwdata & `BISM_ES_SRC_MASK;
      end
      if (wrPinDir) begin
        pinDir <= pwdata[7:0];
      end
    end
  end

  // mailboxes, one word each
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : gMbox
      reg [31:0] box;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          box <= `BISM_RST_MBOX;
        end else if (mboxWr[m]) begin
          box <= pwdata;
        end
      end
      assign mboxRd[m*32 +: 32] = box;
    end
  endgenerate

  // source vector: normal sources 0..31, exceptions 32..63
  wire [63:0] srcAct;
  assign srcAct[31:0]  = normStat & normEn & `BISM_NS_SRC_MASK;
  assign srcAct[63:32] = excStat & excEn & `BISM_ES_SRC_MASK;

  // per-source pin selector, eight nibbles per map word
  genvar s;
  generate
    for (s = 0; s < 64; s = s + 1) begin : gMap
      reg [2:0] sel;
      wire wrSel = wrAcc && hitMap && (wordIdx == s / 8);
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sel <= `BISM_RST_MAP;
        end else if (wrSel) begin
          sel <= pwdata[(s % 8) * 4 +: 3];
        end
      end
      assign mapFlat[s*3 +: 3] = sel;
      assign mapRd[s*4 +: 4]   = {1'b0, sel};
    end
  endgenerate

  // gather mapped requests per pin, one or-tree per pin;
  // wide but shallow, which keeps the pin path short
  wire [7:0] pinReq;
  genvar p;
  genvar q;
  generate
    for (p = 0; p < 8; p = p + 1) begin : gPin
      wire [63:0] hit;
      for (q = 0; q < 64; q = q + 1) begin : gHit
        assign hit[q] = srcAct[q] && (mapFlat[q*3 +: 3] == p);
      end
      assign pinReq[p] = |hit;
    end
  endgenerate

  // an input pin never drives, even if sources map to it
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      irqPinOe <= 8'h00;
    else
      irqPinOe <= pinReq & pinDir;
  end

  // read mux
  reg [31:0] rdMux;
  reg        rdErr;
  always @* begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    if (hitMap) begin
      rdMux = mapRd[wordIdx*32 +: 32];
    end else if (hitMbox) begin
      rdMux = mboxRd[wordIdx*32 +: 32];
    end else begin
      case (addrW)
        `BISM_OFS_NORM_STAT: begin
          rdMux = normStat;
        end
        `BISM_OFS_EXC_STAT: begin
          rdMux = excStat;
        end
        `BISM_OFS_NORM_EN: begin
          rdMux = normEn;
        end
        `BISM_OFS_EXC_EN: begin
          rdMux = excEn;
        end
        `BISM_OFS_DOORBELL: begin
          // write-only strobe register, nothing to show
          rdMux = 32'h00000000;
        end
        `BISM_OFS_PIN_DIR: begin
          rdMux = {24'h000000, pinDir};
        end
        default: begin
          rdErr = 1'b1;
        end
      endcase
    end
  end

  // read data and error captured in the setup cycle, held through access
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= pwrite ? 32'h00000000 : rdMux;
      pslverr <= rdErr;
    end
  end

  // handler ordering is software's job; the pin follows the bits it clears

endmodule // bism_irq_ctrl

/* File: bism_irq_ctrl_checker.sv */
// concurrent checks on the interrupt status block ports
// assumes an apb master that holds each request through its access cycle
`timescale 1ns/100ps
module bism_irq_ctrl_checker (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // sources and pins
  input wire        outboundPending,
  input wire [7:0]  irqPinOe
);
  logic [7:0] dirShadow;
  logic       enWritten;
  wire        mapped = paddr < 8'h18 || (paddr >= 8'h40 && paddr < 8'h80);
  wire        setupCyc = psel && !penable;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // shadow of direction and enable writes, since the checker sees only ports
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dirShadow <= 8'h00;
      enWritten <= 1'b0;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr[7:2] == 6'h05) dirShadow <= pwdata[7:0];
      if (paddr[7:2] == 6'h02 || paddr[7:2] == 6'h03) enWritten <= 1'b1;
    end
  end

  sequence xfer;
    setupCyc ##1 (psel && penable && pready);
  endsequence

  reset_clear_a: assert property ($fell(rst) |-> irqPinOe == 8'h00 && prdata == 32'h00000000)
    else $error("outputs not clear after reset");
  unmapped_err_a: assert property (setupCyc && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setupCyc && mapped |=> !pslverr)
    else $error("mapped access refused");
  doorbell_read_a: assert property (setupCyc && !pwrite && paddr[7:2] == 6'h04 |=> prdata == 32'h00000000)
    else $error("doorbell reads nonzero");
  read_hold_a: assert property (xfer |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved after access");
  outbound_mirror_a: assert property (setupCyc && !pwrite && paddr[7:2] == 6'h00 |=>
    prdata[29] == $past(outboundPending, 2)) else $error("outbound bit does not follow input");
  pin_dir_a: assert property ((irqPinOe & ~$past(dirShadow)) == 8'h00)
    else $error("input pin driven");
  enable_gate_a: assert property (!$past(enWritten) |-> irqPinOe == 8'h00)
    else $error("pin driven with enables clear");
endmodule // bism_irq_ctrl_checker

/* File: bism_pin_partner.sv */
// far side of the interrupt pins: pulled-up wires and external requesters
// assumes the device pulls a pin low while its output enable is high
`timescale 1ns/100ps
module bism_pin_partner (
  // clock
  input  wire       clk_sys,
  // device side
  input  wire [7:0] irqPinOe,
  // external requesters, a slow one answers a cycle late
  input  wire [7:0] extReq,
  input  wire       slowReq,
  // resolved pin levels
  output wire [7:0] irqPinInN
);
  logic [7:0] reqLate = 8'h00;
  always @(posedge clk_sys) reqLate <= extReq;
  // pull-up wins unless some party drives low
  assign irqPinInN = ~(irqPinOe | (slowReq ? reqLate : extReq));
endmodule // bism_pin_partner

/* File: bism_irq_ctrl_tb.sv */
// self-checking bench for the interrupt status block
// assumes zero-wait apb answers and pins resolved by the partner model
`timescale 1ns/100ps
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin nFail++; $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module bism_irq_ctrl_tb;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, outP = 0, inP = 0, slow = 0;
  logic [7:0]  paddr = 8'h00, extReq = 8'h00, irqPinOe, irqPinInN;
  logic [31:0] pwdata = 32'h0, rd, prdata, eNorm, mbox [8];
  logic [7:0]  zeroAdr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40, 8'h60, 8'h7C};
  logic [3:0]  dma = 4'h0, eDma;
  logic [23:0] exc = 24'h0, eExc;
  logic [2:0]  pin;
  logic        pslverr;
  wire         pready;
  wire [7:0]   pinOut;
  int          nFail = 0, totalChecks = 0, seed = 32'hfb9f;

  bism_irq_ctrl bism_irq_ctrl_inst (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .outboundPending(outP), .inboundPending(inP), .dmaChannelEvent(dma), .cpuBusErr(exc[2:0]),
    .cpuDataParityErr(exc[5:3]), .cpuRetryOverflow(exc[8:6]), .cpuAddrParityErr(exc[9]),
    .portOneBusErr(exc[12:10]), .portOneRetryOverflow(exc[15:13]), .portOneAddrParityErr(exc[16]),
    .portTwoBusErr(exc[19:17]), .portTwoRetryOverflow(exc[22:20]), .portTwoAddrParityErr(exc[23]),
    .irqPinInN, .irqPinOut(pinOut), .irqPinOe);
  bism_pin_partner bism_pin_partner_inst (.clk_sys, .irqPinOe, .extReq, .slowReq(slow), .irqPinInN);

  initial forever #20 clk_sys = ~clk_sys;

  task automatic endSim;
    if (nFail == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      nFail++;
      endSim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  function automatic logic [31:0] w1c(input logic [31:0] s, input logic [31:0] w);
    return s & ~w;
  endfunction

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (zeroAdr[k]) rdChk(zeroAdr[k], 32'h0);
    rdChk(8'h20, 32'h0);
    `CHK(err, 1'b1)
    // queue, dma, exception and pin sources at once, pin request through the slow partner path
    pin = 3'($random(seed));
    eDma = 4'($random(seed)) | 4'h1;
    eExc = 24'($random(seed)) | 24'h1;
    slow <= 1'b1;
    outP <= 1'b1;
    inP <= 1'b1;
    dma <= eDma;
    exc <= eExc;
    extReq <= 8'h01 << pin;
    @(posedge clk_sys);
    inP <= 1'b0;
    dma <= 4'h0;
    exc <= 24'h0;
    extReq <= 8'h00;
    foreach (mbox[k]) begin
      mbox[k] = $random(seed);
      apb(1'b1, 8'h60 + 8'(k * 4), mbox[k]);
    end
    apb(1'b1, 8'h10, 32'h0000FFFF);
    eNorm = {4'hB, eDma, 8'h01 << pin, 16'hFFFF};
    rdChk(8'h00, eNorm);
    rdChk(8'h04, {8'h80, eExc});
    foreach (mbox[k]) rdChk(8'h60 + 8'(k * 4), mbox[k]);
    apb(1'b1, 8'h00, 32'h0000000F);
    rdChk(8'h00, w1c(eNorm, 32'h0000000F));
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    rdChk(8'h00, 32'h20000000);
    rdChk(8'h04, 32'h80000000);
    outP <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdChk(8'h00, 32'h0);
    rdChk(8'h04, 32'h0);
    // one source steered to a random output pin
    apb(1'b1, 8'h14, 32'h1 << pin);
    apb(1'b1, 8'h40, {29'h0, pin});
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h60, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irqPinOe, 8'h01 << pin)
    `CHK(pinOut, 8'h00)
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irqPinOe, 8'h00)
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h60, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irqPinOe, 8'h00)
    rdChk(8'h00, 32'h1);
    endSim();
  end

  // cuts a hang short
  initial begin
    repeat (50000) @(posedge clk_sys);
    nFail++;
    endSim();
  end
endmodule // bism_irq_ctrl_tb

bind bism_irq_ctrl bism_irq_ctrl_checker bism_irq_ctrl_checker_inst (.clk_sys, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .outboundPending, .irqPinOe);
